// ---- hw/scm_regs.svh ----
// Register offsets, field positions, reset values and timing counts
`ifndef SCM_REGS_SVH
`define SCM_REGS_SVH

// ==========================================================
// Device register offsets
`define SCM_REG_MODE 8'h03
`define SCM_REG_FORMAT 8'h04
`define SCM_REG_CLKCFG 8'h05
`define SCM_REG_OUTDIV 8'h06
`define SCM_REG_OUTN 8'h07
`define SCM_REG_STATUS 8'h08
`define SCM_REG_PVCFG 8'h10
`define SCM_REG_PVDT 8'h11

// ==========================================================
// Host local registers
`define SCM_HOST_LOCAL_BIT 7
`define SCM_HREG_STATUS 8'h80

// ==========================================================
// Field positions
`define SCM_MODE_OVR_BIT 4
`define SCM_FMT_RAW12_BIT 0
`define SCM_FMT_OVR_BIT 1
`define SCM_CLK_DIV2_BIT 0
`define SCM_CLK_SENSOR_EN_BIT 1
`define SCM_CLK_HALF_BIT 2
`define SCM_CLK_OSC_BIT 3
`define SCM_PV_MATCH_EN_BIT 0
`define SCM_HST_DIV_BIT 0
`define SCM_HST_INT_BIT 1

// ==========================================================
// Reset values and divider code limits
`define SCM_MODE_RST 3'h0
`define SCM_CLKCFG_RST 8'h00
`define SCM_OUTDIV_RST 8'h41
`define SCM_OUTN_RST 8'h1e
`define SCM_DIVCODE_MIN 3'h2
`define SCM_DIVCODE_MAX 3'h4

// ==========================================================
// Rate multipliers and bandwidth caps
`define SCM_FC_SYNC 8'ha0
`define SCM_BW_SYNC 8'h80
`define SCM_FC_EXT1 8'h50
`define SCM_BW_EXT1 8'h40
`define SCM_FC_EXT2 8'h28
`define SCM_BW_EXT2 8'h20
`define SCM_FC_PV 8'h1c
`define SCM_BW_PV 8'h14

// ==========================================================
// Reference ranges in 0.1 MHz units
`define SCM_SYNC_LO 11'd230
`define SCM_SYNC_HI 11'd260
`define SCM_HALF_LO 11'd115
`define SCM_HALF_HI 11'd130
`define SCM_EXT1_LO 11'd250
`define SCM_EXT1_HI 11'd520
`define SCM_EXT2_LO 11'd500
`define SCM_EXT2_HI 11'd1040
`define SCM_INT_LO 11'd484
`define SCM_INT_HI 11'd510
`define SCM_PV10_LO 11'd250
`define SCM_PV10_HI 11'd665
`define SCM_PV12_LO 11'd250
`define SCM_PV12_HI 11'd700

// ==========================================================
// Packet data types and timing
`define SCM_DT_RAW10 6'h2b
`define SCM_DT_RAW12 6'h2c
`define SCM_CLK_PERIOD_NS 10
`define SCM_MEAS_WINDOW_NS 10000
`define SCM_MEAS_CYCLES (`SCM_MEAS_WINDOW_NS / `SCM_CLK_PERIOD_NS)

`endif

// ---- hw/scm_pkg.sv ----
// Types shared by both ends of the clock mode control link
`default_nettype none

package scm_pkg;
  typedef enum logic [2:0] {
    SCM_MODE_SYNC = 3'h0,
    SCM_MODE_NSEXT = 3'h2,
    SCM_MODE_NSINT = 3'h3,
    SCM_MODE_PVEXT = 3'h5
  } scm_mode_e;

  typedef enum logic [1:0] {
    SCM_REF_BACK = 2'h0,
    SCM_REF_EXT = 2'h1,
    SCM_REF_AON = 2'h2
  } scm_ref_e;

  typedef logic [7:0] scm_byte_t;
endpackage

`default_nettype wire

// ---- hw/scm_link_if.sv ----
// Register path between the configuring host and the serializer
`default_nettype none

interface scm_link_if;
  scm_pkg::scm_byte_t addr;
  scm_pkg::scm_byte_t wdata;
  logic wr;
  logic rd;
  scm_pkg::scm_byte_t rdata;

  modport dev (input addr, input wdata, input wr, input rd, output rdata);
  modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface

`default_nettype wire

// ---- hw/scm_frac_clk.sv ----
// Fractional sensor clock generator: rate = ref x step / limit
`default_nettype none

module scm_frac_clk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic restart_i,
  input wire logic enable_i,
  input wire logic ref_tick_i,
  input wire logic [12:0] step_i,
  input wire logic [14:0] limit_i,
  // Output
  output logic clk_o
);
  logic [17:0] acc;
  logic [17:0] next_acc;
  logic take;

  // Each reference edge adds twice the step; each crossing toggles once,
  // so one half output period is spent per limit
  always_comb begin
    take = (limit_i != 15'h0000) && (acc >= {3'h0, limit_i});
    next_acc = acc;
    if (take) begin
      next_acc = next_acc - {3'h0, limit_i};
    end
    if (ref_tick_i) begin
      next_acc = next_acc + {4'h0, step_i, 1'b0};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || !enable_i) begin
      acc <= 18'h00000;
    end else begin
      acc <= next_acc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || restart_i || !enable_i) begin
      clk_o <= 1'b0;
    end else if (take) begin
      clk_o <= ~clk_o;
    end
  end
endmodule

`default_nettype wire

// ---- hw/scm_device.sv ----
// Serializer clock mode selection, reference check and sensor clock
// Clock mode rules; RL6 and RL9 are kept in the host
// RL1 - Synchronous: back reference, 160x rate, 128x bandwidth
// RL2 - External, divide one: 25-52 MHz, 80x, 64x
// RL3 - External, divide two: 50-104 MHz, 40x, 32x
// RL4 - Internal oscillator: 48.4-51 MHz, 80x, no sensor clock
// RL5 - Parallel video: 25-66.5/70 MHz, 28x, 20x
// RL6 - Software programs output divider 16, 8 or 4
// RL7 - Synchronous back reference feeds link and sensor clock
// RL8 - Source keeps image throughput below line rate
// RL9 - Internal mode needs oscillator select, sensor clock off
// RL10 - Internal mode: sensor clock off, always-on reference
// RL11 - Mode field reports mode; read-only unless override
// RL12 - Power-down pin rise latches strapped mode
// RL13 - Override set makes mode field writable
// RL14 - Parallel source data follows external reference
// RL15 - Sync and external modes drive sensor clock
// RL16 - Sensor clock = rate x M / (divider x N)
// RL17 - Integer N/M gives clean fractional output
// RL18 - Format override and parallel config registers
// RL19 - Match enable passes packets of programmed type
// RL20 - Rate over divider stays below 1.05 GHz
// RL21 - Mode codes: 0, 2, 3, 5
// RL22 - Mode rewrite re-derives rate and output clock
//
// Chosen here: the strobed register port.
`include "scm_regs.svh"
`default_nettype none

module scm_device #(
  parameter int MEAS_CYCLES = `SCM_MEAS_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register path
  scm_link_if.dev link,
  // Pins
  input wire logic power_down_pin_i,
  input wire logic [2:0] mode_strap_i,
  input wire logic back_ref_tick_i,
  input wire logic external_ref_clock_input_i,
  input wire logic always_on_oscillator_i,
  // Packet filter
  input wire logic pkt_valid_i,
  input wire logic [5:0] pkt_dt_i,
  output logic pkt_pass_o,
  // Derived clocking
  output logic [7:0] fc_rate_mult_o,
  output logic [7:0] csi_bw_mult_o,
  output logic [1:0] ref_source_o,
  output logic ref_in_range_o,
  output logic sensor_clk_en_o,
  output logic sensor_clk_o
);
  generate
    if (MEAS_CYCLES < 2 || MEAS_CYCLES > 65535) begin : g_bad_meas
      $error("MEAS_CYCLES must lie in 2..65535");
    end
  endgenerate

  // ==========================================================
  // Pin synchronisers
  logic [6:0] pin_s1;
  logic [6:0] pin_s2;
  logic [6:0] pin_s3;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_s1 <= 7'h00;
      pin_s2 <= 7'h00;
      pin_s3 <= 7'h00;
    end else begin
      pin_s1 <= {mode_strap_i, power_down_pin_i, always_on_oscillator_i,
                 external_ref_clock_input_i, back_ref_tick_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  logic [3:0] rise;
  assign rise = pin_s2[3:0] & ~pin_s3[3:0];

  // ==========================================================
  // Registers
  logic [2:0] mode_field;
  logic mode_ovr;
  scm_pkg::scm_byte_t fmt;
  scm_pkg::scm_byte_t clkcfg;
  scm_pkg::scm_byte_t outdiv;
  scm_pkg::scm_byte_t outn;
  scm_pkg::scm_byte_t pvcfg;
  scm_pkg::scm_byte_t pvdt;

  function automatic logic hit(input scm_pkg::scm_byte_t a);
    return link.wr && (link.addr == a);
  endfunction

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_field <= `SCM_MODE_RST;
    end else if (rise[3]) begin
      mode_field <= pin_s2[6:4]; // RL12
    end else if (hit(`SCM_REG_MODE) && mode_ovr) begin
      mode_field <= link.wdata[2:0]; // RL13
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_ovr <= 1'b0;
    end else if (hit(`SCM_REG_MODE)) begin
      mode_ovr <= link.wdata[`SCM_MODE_OVR_BIT]; // RL11
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fmt <= 8'h00;
      clkcfg <= `SCM_CLKCFG_RST;
      outdiv <= `SCM_OUTDIV_RST;
      outn <= `SCM_OUTN_RST;
      pvcfg <= 8'h00;
      pvdt <= 8'h00;
    end else begin
      if (hit(`SCM_REG_FORMAT)) fmt <= link.wdata; // RL18
      if (hit(`SCM_REG_CLKCFG)) clkcfg <= link.wdata;
      if (hit(`SCM_REG_OUTDIV)) outdiv <= link.wdata; // RL16
      if (hit(`SCM_REG_OUTN)) outn <= link.wdata; // RL16
      if (hit(`SCM_REG_PVCFG)) pvcfg <= link.wdata; // RL18
      if (hit(`SCM_REG_PVDT)) pvdt <= link.wdata; // RL19
    end
  end

  // ==========================================================
  // Mode derivation
  logic div2;
  logic half;
  logic raw12;
  assign div2 = clkcfg[`SCM_CLK_DIV2_BIT];
  assign half = clkcfg[`SCM_CLK_HALF_BIT];
  assign raw12 = fmt[`SCM_FMT_OVR_BIT] && fmt[`SCM_FMT_RAW12_BIT];

  logic [7:0] fc_mult;
  logic [7:0] bw_mult;
  logic [1:0] ref_src;
  logic [10:0] lo;
  logic [10:0] hi;
  always_comb begin
    fc_mult = `SCM_FC_SYNC; // RL1
    bw_mult = `SCM_BW_SYNC;
    ref_src = scm_pkg::SCM_REF_BACK; // RL7
    lo = half ? `SCM_HALF_LO : `SCM_SYNC_LO;
    hi = half ? `SCM_HALF_HI : `SCM_SYNC_HI;
    case (mode_field) // RL21
      scm_pkg::SCM_MODE_NSEXT: begin
        ref_src = scm_pkg::SCM_REF_EXT;
        fc_mult = div2 ? `SCM_FC_EXT2 : `SCM_FC_EXT1; // RL2 RL3
        bw_mult = div2 ? `SCM_BW_EXT2 : `SCM_BW_EXT1;
        lo = div2 ? `SCM_EXT2_LO : `SCM_EXT1_LO;
        hi = div2 ? `SCM_EXT2_HI : `SCM_EXT1_HI;
      end
      scm_pkg::SCM_MODE_NSINT: begin
        ref_src = scm_pkg::SCM_REF_AON; // RL10
        fc_mult = `SCM_FC_EXT1; // RL4
        bw_mult = `SCM_BW_EXT1;
        lo = `SCM_INT_LO;
        hi = `SCM_INT_HI;
      end
      scm_pkg::SCM_MODE_PVEXT: begin
        ref_src = scm_pkg::SCM_REF_EXT;
        fc_mult = `SCM_FC_PV; // RL5
        bw_mult = `SCM_BW_PV;
        lo = raw12 ? `SCM_PV12_LO : `SCM_PV10_LO;
        hi = raw12 ? `SCM_PV12_HI : `SCM_PV10_HI;
      end
      default: begin
        ref_src = scm_pkg::SCM_REF_BACK;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fc_rate_mult_o <= `SCM_FC_SYNC;
      csi_bw_mult_o <= `SCM_BW_SYNC;
      ref_source_o <= scm_pkg::SCM_REF_BACK;
    end else begin
      fc_rate_mult_o <= fc_mult;
      csi_bw_mult_o <= bw_mult;
      ref_source_o <= ref_src;
    end
  end

  // Any change of the active mode restarts measurement and output clock
  logic [2:0] mode_prev;
  logic [9:0] cfg_prev;
  logic rederive;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_prev <= `SCM_MODE_RST;
      cfg_prev <= 10'h000;
    end else begin
      mode_prev <= mode_field;
      cfg_prev <= {div2, half, fc_mult};
    end
  end
  assign rederive = (mode_prev != mode_field) || (cfg_prev != {div2, half, fc_mult}); // RL22

  // ==========================================================
  // Reference frequency check
  logic ref_tick;
  assign ref_tick = (ref_src == scm_pkg::SCM_REF_AON) ? rise[2] :
                    (ref_src == scm_pkg::SCM_REF_EXT) ? rise[1] : rise[0];

  logic [15:0] win_cnt;
  logic [10:0] tick_cnt;
  logic win_end;
  assign win_end = (win_cnt == 16'(MEAS_CYCLES - 1));

  always_ff @(posedge clk_i) begin
    if (rst_i || rederive || win_end) begin
      win_cnt <= 16'h0000;
    end else begin
      win_cnt <= win_cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rederive || win_end) begin
      tick_cnt <= 11'h000;
    end else if (ref_tick && tick_cnt != 11'h7ff) begin
      tick_cnt <= tick_cnt + 11'h001;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || rederive) begin
      ref_in_range_o <= 1'b0;
    end else if (win_end) begin
      ref_in_range_o <= (tick_cnt >= lo) && (tick_cnt <= hi); // RL1 RL2 RL3 RL4 RL5
    end
  end

  // ==========================================================
  // Sensor clock output
  logic out_en;
  logic [12:0] step;
  logic [14:0] limit;
  assign out_en = (mode_field != scm_pkg::SCM_MODE_NSINT) &&
                  clkcfg[`SCM_CLK_SENSOR_EN_BIT]; // RL10 RL15
  assign step = 13'(fc_mult * outdiv[4:0]);
  assign limit = 15'({outn, 7'h00} >> (3'h7 - outdiv[7:5])); // RL16 RL17

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sensor_clk_en_o <= 1'b0;
    end else begin
      sensor_clk_en_o <= out_en;
    end
  end

  scm_frac_clk u_frac (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .restart_i(rederive),
    .enable_i(out_en),
    .ref_tick_i(ref_tick), // RL7
    .step_i(step),
    .limit_i(limit),
    .clk_o(sensor_clk_o)
  );

  // ==========================================================
  // Parallel video packet filter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pkt_pass_o <= 1'b0;
    end else if (!pkt_valid_i || mode_field != scm_pkg::SCM_MODE_PVEXT) begin
      pkt_pass_o <= 1'b0;
    end else if (pvcfg[`SCM_PV_MATCH_EN_BIT]) begin
      pkt_pass_o <= (pkt_dt_i == pvdt[5:0]); // RL19
    end else begin
      pkt_pass_o <= (pkt_dt_i == (raw12 ? `SCM_DT_RAW12 : `SCM_DT_RAW10)); // RL18
    end
  end

  // ==========================================================
  // Read port
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link.rdata <= 8'h00;
    end else if (link.rd) begin
      case (link.addr)
        `SCM_REG_MODE: link.rdata <= {3'h0, mode_ovr, 1'b0, mode_field}; // RL11
        `SCM_REG_FORMAT: link.rdata <= fmt;
        `SCM_REG_CLKCFG: link.rdata <= clkcfg;
        `SCM_REG_OUTDIV: link.rdata <= outdiv;
        `SCM_REG_OUTN: link.rdata <= outn;
        `SCM_REG_STATUS: link.rdata <= {4'h0, sensor_clk_en_o, ref_in_range_o, ref_source_o};
        `SCM_REG_PVCFG: link.rdata <= pvcfg;
        `SCM_REG_PVDT: link.rdata <= pvdt;
        default: link.rdata <= 8'h00;
      endcase
    end else begin
      link.rdata <= 8'h00;
    end
  end
endmodule

`default_nettype wire

// ---- hw/scm_host.sv ----
// Configuring host: forwards register commands and refuses unsafe ones
`include "scm_regs.svh"
`default_nettype none

module scm_host (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Command port
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_wdata_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  output logic [7:0] cmd_rdata_o,
  // Device side
  scm_link_if.host link
);
  // ==========================================================
  // Shadow of the device clock configuration
  logic osc_sel;
  logic sensor_en;
  logic ovr_on;
  logic local_hit;
  assign local_hit = cmd_addr_i[`SCM_HOST_LOCAL_BIT];

  // Divider codes other than 2, 3 and 4 (divide by 4, 8, 16) are refused
  logic div_bad;
  logic int_bad;
  assign div_bad = cmd_wr_i && !local_hit && (cmd_addr_i == `SCM_REG_OUTDIV) &&
                   ((cmd_wdata_i[7:5] < `SCM_DIVCODE_MIN) ||
                    (cmd_wdata_i[7:5] > `SCM_DIVCODE_MAX)); // RL6 RL20
  // Internal mode only once the oscillator is selected and the sensor clock is off
  assign int_bad = cmd_wr_i && !local_hit && (cmd_addr_i == `SCM_REG_MODE) &&
                   (cmd_wdata_i[`SCM_MODE_OVR_BIT] || ovr_on) &&
                   (cmd_wdata_i[2:0] == scm_pkg::SCM_MODE_NSINT) &&
                   !(osc_sel && !sensor_en); // RL9

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_sel <= 1'b0;
      sensor_en <= 1'b0;
    end else if (cmd_wr_i && !local_hit && cmd_addr_i == `SCM_REG_CLKCFG) begin
      osc_sel <= cmd_wdata_i[`SCM_CLK_OSC_BIT];
      sensor_en <= cmd_wdata_i[`SCM_CLK_SENSOR_EN_BIT];
    end
  end

  // The device takes a mode from any write once its override is on
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ovr_on <= 1'b0;
    end else if (link.wr && cmd_addr_i == `SCM_REG_MODE) begin
      ovr_on <= cmd_wdata_i[`SCM_MODE_OVR_BIT];
    end
  end

  // ==========================================================
  // Forwarding
  assign link.addr = cmd_addr_i;
  assign link.wdata = cmd_wdata_i;
  assign link.wr = cmd_wr_i && !local_hit && !div_bad && !int_bad;
  assign link.rd = cmd_rd_i && !local_hit;

  // ==========================================================
  // Sticky refusal flags, write one to clear, a new refusal wins
  logic [1:0] refused;
  logic [1:0] clr;
  assign clr = (cmd_wr_i && cmd_addr_i == `SCM_HREG_STATUS) ? cmd_wdata_i[1:0] : 2'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      refused <= 2'h0;
    end else begin
      refused <= (refused & ~clr) | {int_bad, div_bad};
    end
  end

  logic sel_local;
  logic [7:0] local_rdata;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_local <= 1'b0;
      local_rdata <= 8'h00;
    end else begin
      sel_local <= cmd_rd_i && local_hit;
      local_rdata <= (cmd_rd_i && cmd_addr_i == `SCM_HREG_STATUS) ?
                     {6'h00, refused} : 8'h00;
    end
  end
  assign cmd_rdata_o = sel_local ? local_rdata : link.rdata;
endmodule

`default_nettype wire

// ---- verification/scm_link_properties.sv ----
// Concurrent checks on the register path between host and device
`default_nettype none

module scm_link_properties (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link signals
  input wire scm_pkg::scm_byte_t addr,
  input wire scm_pkg::scm_byte_t wdata,
  input wire logic wr,
  input wire logic rd,
  input wire scm_pkg::scm_byte_t rdata
);
  timeunit 1ns;
  timeprecision 100ps;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // ==========================================================
  // Shadow of what the link has written
  scm_pkg::scm_byte_t div_reg;
  scm_pkg::scm_byte_t n_reg;
  logic ovr;
  logic osc_ok;
  logic mode_known;
  logic [2:0] mode_w;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_reg <= 8'h41;
      n_reg <= 8'h1e;
      ovr <= 1'b0;
      osc_ok <= 1'b0;
      mode_known <= 1'b0;
      mode_w <= 3'h0;
    end else if (wr) begin
      if (addr == 8'h06) div_reg <= wdata;
      if (addr == 8'h07) n_reg <= wdata;
      if (addr == 8'h05) osc_ok <= wdata[3] && !wdata[1];
      if (addr == 8'h03) begin
        ovr <= wdata[4];
        if (ovr) begin
          mode_known <= 1'b1;
          mode_w <= wdata[2:0];
        end
      end
    end
  end

  // ==========================================================
  // Properties
  property p_rdata_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");

  property p_mode_fmt;
    rd && addr == 8'h03 |=> rdata[7:5] == 3'h0 && !rdata[3];
  endproperty
  a_mode_fmt: assert property (p_mode_fmt) else $error("mode register spare bits set");

  property p_mode_code;
    rd && addr == 8'h03 |=> rdata[2:0] inside {3'h0, 3'h2, 3'h3, 3'h5};
  endproperty
  a_mode_code: assert property (p_mode_code) else $error("mode field holds bad code");

  property p_ovr_rb;
    rd && addr == 8'h03 |=> rdata[4] == $past(ovr);
  endproperty
  a_ovr_rb: assert property (p_ovr_rb) else $error("override bit readback wrong");

  property p_mode_rb;
    rd && addr == 8'h03 && mode_known |=> rdata[2:0] == $past(mode_w);
  endproperty
  a_mode_rb: assert property (p_mode_rb) else $error("overridden mode readback wrong");

  property p_div_range;
    wr && addr == 8'h06 |-> wdata[7:5] inside {[3'h2:3'h4]};
  endproperty
  a_div_range: assert property (p_div_range) else $error("bad divider code reached device");

  property p_int_guard;
    wr && addr == 8'h03 && (wdata[4] || ovr) && wdata[2:0] == 3'h3 |-> osc_ok;
  endproperty
  a_int_guard: assert property (p_int_guard) else $error("internal mode without osc select");

  property p_div_rb;
    rd && addr == 8'h06 |=> rdata == $past(div_reg);
  endproperty
  a_div_rb: assert property (p_div_rb) else $error("divider register readback wrong");

  property p_n_rb;
    rd && addr == 8'h07 |=> rdata == $past(n_reg);
  endproperty
  a_n_rb: assert property (p_n_rb) else $error("N register readback wrong");

  property p_status;
    rd && addr == 8'h08 |=> rdata[7:4] == 4'h0 && rdata[1:0] != 2'h3;
  endproperty
  a_status: assert property (p_status) else $error("status register malformed");
endmodule

`default_nettype wire

// ---- verification/serializer_clock_mode_control_bench.sv ----
// Self-checking bench for host and device joined over the register link
`default_nettype none

module serializer_clock_mode_control_bench;
  timeunit 1ns;
  timeprecision 100ps;

  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] cmd_addr = 8'h00;
  logic [7:0] cmd_wdata = 8'h00;
  logic cmd_wr = 1'b0;
  logic cmd_rd = 1'b0;
  logic [7:0] cmd_rdata;
  logic power_down_pin = 1'b0;
  logic [2:0] strap = 3'h0;
  logic back_ref = 1'b0;
  logic ext_ref = 1'b0;
  logic always_on_oscillator = 1'b0;
  logic pkt_valid = 1'b0;
  logic [5:0] pkt_dt = 6'h00;
  logic pkt_pass;
  logic [7:0] fc;
  logic [7:0] bw;
  logic [1:0] src;
  logic in_range;
  logic sen_en;
  logic sen_clk;
  int n_fail = 0;
  int check_count = 0;
  int edges = 0;
  logic counting = 1'b0;
  logic [7:0] d;
  logic [7:0] v;
  logic [5:0] dt;
  longint e;

  // ==========================================================
  // Clocks: 25 MHz back channel, 40 MHz external, 16.7 MHz always-on
  always #5 clk_i = ~clk_i;
  always #20 back_ref = ~back_ref;
  always #12.5 ext_ref = ~ext_ref;
  always #30 always_on_oscillator = ~always_on_oscillator;
  always @(posedge sen_clk) if (counting) edges++;

  scm_link_if link_bus ();

  scm_host u_scm_host (
    .clk_i(clk_i), .rst_i(rst_i), .cmd_addr_i(cmd_addr), .cmd_wdata_i(cmd_wdata),
    .cmd_wr_i(cmd_wr), .cmd_rd_i(cmd_rd), .cmd_rdata_o(cmd_rdata), .link(link_bus)
  );

  scm_device #(.MEAS_CYCLES(1000)) u_scm_device (
    .clk_i(clk_i), .rst_i(rst_i), .link(link_bus), .power_down_pin_i(power_down_pin),
    .mode_strap_i(strap), .back_ref_tick_i(back_ref), .external_ref_clock_input_i(ext_ref),
    .always_on_oscillator_i(always_on_oscillator), .pkt_valid_i(pkt_valid), .pkt_dt_i(pkt_dt),
    .pkt_pass_o(pkt_pass), .fc_rate_mult_o(fc), .csi_bw_mult_o(bw), .ref_source_o(src),
    .ref_in_range_o(in_range), .sensor_clk_en_o(sen_en), .sensor_clk_o(sen_clk)
  );

  scm_link_properties u_scm_link_properties (
    .clk_i(clk_i), .rst_i(rst_i), .addr(link_bus.addr), .wdata(link_bus.wdata),
    .wr(link_bus.wr), .rd(link_bus.rd), .rdata(link_bus.rdata)
  );

  // ==========================================================
  // Tasks
  task automatic final_report;
    $display("checks %0d failures %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      n_fail++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] w);
    @(posedge clk_i);
    cmd_addr <= a;
    cmd_wdata <= w;
    cmd_wr <= 1'b1;
    @(posedge clk_i);
    cmd_wr <= 1'b0;
  endtask

  task automatic rd_reg(input logic [7:0] a, output logic [7:0] r);
    @(posedge clk_i);
    cmd_addr <= a;
    cmd_rd <= 1'b1;
    @(posedge clk_i);
    cmd_rd <= 1'b0;
    #1 r = cmd_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] r;
    rd_reg(a, r);
    chk("register read", exp, r);
  endtask

  task automatic chk_out(input logic [7:0] f, input logic [7:0] b, input logic [1:0] s);
    chk("fc_rate_mult", f, fc);
    chk("csi_bw_mult", b, bw);
    chk("ref_source", s, src);
    chk("bw_below_rate", 1'b1, bw < fc);
  endtask

  task automatic pkt(input logic [5:0] t, input logic exp);
    @(posedge clk_i);
    pkt_valid <= 1'b1;
    pkt_dt <= t;
    @(posedge clk_i);
    pkt_valid <= 1'b0;
    #1 chk("pkt_pass", exp, pkt_pass);
  endtask

  function automatic longint exp_edges(input longint m, input int code, input longint ncyc);
    return 25000 * 160 * m * ncyc / ((longint'(1) << code) * 30 * 100000);
  endfunction

  initial begin
    #500000;
    n_fail++;
    final_report();
  end

  // ==========================================================
  // Main sequence
  initial begin
    void'($urandom(5));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc(2);
    chk_out(8'ha0, 8'h80, 2'h0);
    rd_chk(8'h03, 8'h00);
    rd_chk(8'h06, 8'h41);
    rd_chk(8'h07, 8'h1e);
    rd_reg(8'h08, d);
    chk("status_src", 2'h0, d[1:0]);
    pkt(6'h2b, 1'b0);
    cyc(2200);
    chk("in_range_sync", 1'b1, in_range);
    wr_reg(8'h05, 8'h04);
    cyc(2200);
    chk("in_range_half", 1'b0, in_range);
    wr_reg(8'h05, 8'h00);
    strap <= 3'h2;
    @(posedge clk_i);
    power_down_pin <= 1'b1;
    cyc(6);
    chk_out(8'h50, 8'h40, 2'h1);
    rd_chk(8'h03, 8'h02);
    wr_reg(8'h03, 8'h15);
    rd_chk(8'h03, 8'h12);
    cyc(2200);
    chk("in_range_ext1", 1'b1, in_range);
    wr_reg(8'h05, 8'h01);
    cyc(3);
    chk_out(8'h28, 8'h20, 2'h1);
    cyc(2200);
    chk("in_range_ext2", 1'b0, in_range);
    wr_reg(8'h05, 8'h00);
    wr_reg(8'h03, 8'h15);
    cyc(3);
    chk_out(8'h1c, 8'h14, 2'h1);
    rd_chk(8'h03, 8'h15);
    pkt(6'h2b, 1'b1);
    pkt(6'h2c, 1'b0);
    wr_reg(8'h04, 8'h03);
    pkt(6'h2c, 1'b1);
    pkt(6'h2b, 1'b0);
    wr_reg(8'h10, 8'h01);
    for (int i = 0; i < 4; i++) begin
      dt = 6'($urandom % 64);
      wr_reg(8'h11, {2'h0, dt});
      pkt(dt, 1'b1);
      pkt(dt ^ 6'h01, 1'b0);
    end
    wr_reg(8'h05, 8'h02);
    wr_reg(8'h03, 8'h13);
    cyc(3);
    chk("fc_refused", 8'h1c, fc);
    rd_reg(8'h80, d);
    chk("host_int_refused", 1'b1, d[1]);
    wr_reg(8'h80, 8'h02);
    rd_reg(8'h80, d);
    chk("host_status_clear", 1'b0, d[1]);
    wr_reg(8'h05, 8'h08);
    wr_reg(8'h03, 8'h13);
    cyc(3);
    chk_out(8'h50, 8'h40, 2'h2);
    chk("sensor_en_int", 1'b0, sen_en);
    rd_chk(8'h03, 8'h13);
    for (int i = 0; i < 6; i++) begin
      v = {3'(2 + $urandom % 3), 5'(1 + $urandom % 31)};
      wr_reg(8'h06, v);
      rd_chk(8'h06, v);
      wr_reg(8'h06, {3'(i % 2 ? 5 : 1), v[4:0]});
      rd_chk(8'h06, v);
      rd_reg(8'h80, d);
      chk("host_div_refused", 1'b1, d[0]);
      wr_reg(8'h80, 8'h01);
    end
    wr_reg(8'h03, 8'h10);
    wr_reg(8'h05, 8'h02);
    wr_reg(8'h07, 8'h1e);
    cyc(3);
    chk_out(8'ha0, 8'h80, 2'h0);
    chk("sensor_en_sync", 1'b1, sen_en);
    for (int code = 2; code < 4; code++) begin
      wr_reg(8'h06, {3'(code), 5'h01});
      cyc(50);
      edges = 0;
      counting = 1'b1;
      cyc(3000);
      counting = 1'b0;
      e = exp_edges(1, code, 3000);
      chk("sensor_clk_rate", 1'b1, edges * 50 > e * 49 && edges * 50 < e * 51);
    end
    final_report();
  end
endmodule

`default_nettype wire
